// File: src/fsi_pkg.sv
// Constants and types for the flash interface state controller
package fsi_pkg;

  // ****************************************
  // Interface states, one-hot
  // ****************************************
  typedef enum logic [17:0] {
    ST_PWR_UP   = 18'h00001,
    ST_STANDBY  = 18'h00002,
    ST_INSTR    = 18'h00004,
    ST_SIN      = 18'h00008,
    ST_SLAT     = 18'h00010,
    ST_SOUT     = 18'h00020,
    ST_DIN      = 18'h00040,
    ST_DLAT     = 18'h00080,
    ST_DOUT     = 18'h00100,
    ST_QIN      = 18'h00200,
    ST_QLAT     = 18'h00400,
    ST_QOUT     = 18'h00800,
    ST_XIN      = 18'h01000,
    ST_XLAT     = 18'h02000,
    ST_XOUT     = 18'h04000,
    ST_RST_BUSY = 18'h08000,
    ST_SLEEP    = 18'h10000,
    ST_WAKE     = 18'h20000
  } fsi_state_t;

  // ****************************************
  // Command formats, codes and pin masks
  // ****************************************
  localparam logic [2:0] FMT_NONE  = 3'h0;
  localparam logic [2:0] FMT_WRITE = 3'h1;
  localparam logic [2:0] FMT_SREAD = 3'h2;
  localparam logic [2:0] FMT_DREAD = 3'h3;
  localparam logic [2:0] FMT_QREAD = 3'h4;
  localparam logic [2:0] FMT_XREAD = 3'h5;
  localparam logic [7:0] CMD_DEEP_SLEEP = 8'hB9;
  localparam logic [7:0] CMD_RELEASE    = 8'hAB;
  localparam logic [7:0] IDLE_FILL      = 8'hFF;
  localparam logic [3:0] OE_NONE   = 4'h0;
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_DUAL   = 4'h3;
  localparam logic [3:0] OE_QUAD   = 4'hF;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] INSTR_CYC_SPI = 8'h08;
  localparam logic [7:0] INSTR_CYC_QPI = 8'h02;
  localparam int IDX_DATA3 = 3;

  // ****************************************
  // Clock in MHz, timing in ns, and sizes
  // ****************************************
  localparam int CLK_MHZ         = 125;
  localparam int NS_PER_US       = 1000;
  localparam int POWER_UP_NS     = 300000;
  localparam int RESET_PULSE_NS  = 200;
  localparam int RESET_BUSY_NS   = 35000;
  localparam int RESET_HOLD_NS   = 50;
  localparam int WAKE_NS         = 3000;
  localparam int TIMER_W         = 24;
  localparam int RCNT_W          = 16;
  localparam int FIFO_W          = 8;
  localparam int FIFO_D          = 16;

endpackage

// File: src/fsi_iface_states.sv
// Flash serial interface state controller with its read data FIFO
`timescale 1ns/10ps
// Behaviour
// - Low supply: ignore all commands
// - Power-up interval: silent, then enter standby
// - Data3 resets only outside quad or CS high
// - Reset pulse, busy time, hold, then standby
// - CS high: standby, ignore all but reset
// - CS fall in standby starts instruction capture
// - Deep sleep accepted only when not busy
// - Asleep: only release command, wake delay
// - Data1 floats in idle and input states
// - Output states drive one, two, four lines
// - Latency data is ignored by the device
// - DDR latency may float; we float
// - Each command framed by CS low

// ****************************************
// Read data FIFO
// ****************************************
module fsi_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         mclk,      // System clock
  input  wire logic         reset,     // Async reset
  input  wire logic         in_valid,  // Write request
  input  wire logic [W-1:0] in_data,   // Write word
  output logic              in_ready,  // Room left
  output logic              out_valid, // Word available
  output logic [W-1:0]      out_data,  // Head word
  input  wire logic         out_ready  // Pop head
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } fsi_fifo_q_t;

  fsi_fifo_q_t q;
  fsi_fifo_q_t next_q;
  logic        push;
  logic        pop;

  if (D < 2 || (1 << AW) != D)
  begin : g_chk
    $error("FIFO depth must be a power of two");
  end

  assign in_ready  = q.cnt != (AW+1)'(D);
  assign out_valid = q.cnt != '0;
  assign out_data  = q.mem[q.rp];

  always_comb
  begin
    next_q = q;
    push   = in_valid && in_ready;
    pop    = out_ready && out_valid;
    if (push)
    begin
      next_q.mem[q.wp] = in_data;
      next_q.wp        = q.wp + 1'b1;
    end
    if (pop)
      next_q.rp = q.rp + 1'b1;
    if (push && !pop)
      next_q.cnt = q.cnt + 1'b1;
    else if (pop && !push)
      next_q.cnt = q.cnt - 1'b1;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      q <= '0;
    else
      q <= next_q;
  end
endmodule

// ****************************************
// Interface state controller
// ****************************************
module fsi_iface_states #(
  parameter int CLK_MHZ        = fsi_pkg::CLK_MHZ,
  parameter int POWER_UP_NS    = fsi_pkg::POWER_UP_NS,
  parameter int RESET_PULSE_NS = fsi_pkg::RESET_PULSE_NS,
  parameter int RESET_BUSY_NS  = fsi_pkg::RESET_BUSY_NS,
  parameter int RESET_HOLD_NS  = fsi_pkg::RESET_HOLD_NS,
  parameter int WAKE_NS        = fsi_pkg::WAKE_NS,
  parameter int FIFO_DEPTH     = fsi_pkg::FIFO_D
) (
  input  wire logic       mclk,              // System clock
  input  wire logic       reset,             // Async reset
  input  wire logic       supply_good,       // Core supply above cut-off
  input  wire logic       sck,               // Serial clock pin
  input  wire logic       cs_n,              // Chip select pin
  input  wire logic [3:0] pin_in,            // data3_or_reset_n..serial_in_data0
  output logic      [3:0] pin_out,           // Pin output levels
  output logic      [3:0] pin_oe,            // Pin drive enables
  input  wire logic       reset_enable,      // Data3 may reset
  input  wire logic       quad_mode,         // config_one_volatile quad bit
  input  wire logic       all_quad_protocol, // config_two_volatile bit
  input  wire logic       write_in_progress, // status_one_volatile bit 0
  input  wire logic [2:0] cmd_fmt,           // Format of instr
  input  wire logic [7:0] addr_cycles,       // Address cycles of instr
  input  wire logic [7:0] latency_cycles,    // Latency cycles of instr
  output logic      [7:0] instr,             // Last instruction
  output logic      [7:0] rx_data,           // Received byte
  output logic            rx_valid,          // Byte pulse
  input  wire logic       tx_valid,          // Read data offered
  input  wire logic [7:0] tx_data,           // Read data byte
  output logic            tx_ready,          // FIFO has room
  output fsi_pkg::fsi_state_t state,         // Interface state
  output logic            deep_sleep         // In deep sleep
);
  function automatic int cyc(input int ns, input bit up);
    int v;
    v = up ? (ns * CLK_MHZ + fsi_pkg::NS_PER_US - 1) / fsi_pkg::NS_PER_US
           : (ns * CLK_MHZ) / fsi_pkg::NS_PER_US;
    return (v < 1) ? 1 : v;
  endfunction

  localparam int PU_CYC  = cyc(POWER_UP_NS, 1'b1);
  localparam int RP_CYC  = cyc(RESET_PULSE_NS, 1'b1);
  localparam int RPH_CYC = cyc(RESET_BUSY_NS, 1'b1);
  localparam int RH_CYC  = cyc(RESET_HOLD_NS, 1'b1);
  localparam int RES_CYC = cyc(WAKE_NS, 1'b1);
  localparam int TW      = fsi_pkg::TIMER_W;
  localparam int RW      = fsi_pkg::RCNT_W;

  if (PU_CYC >= (1 << TW) || RPH_CYC >= (1 << TW) || RES_CYC >= (1 << TW)
      || RP_CYC >= (1 << RW) || RH_CYC >= (1 << RW))
  begin : g_chk
    $error("Timing parameter too large for counters");
  end

  typedef struct packed {
    logic [2:0]          sck_s;
    logic [2:0]          cs_s;
    logic [3:0]          io_a;
    logic [3:0]          io_b;
    logic [1:0]          sup_s;
    fsi_pkg::fsi_state_t st;
    logic [TW-1:0]       timer;
    logic [RW-1:0]       rcnt;
    logic                rlvl;
    logic [7:0]          pc;
    logic                wr;
    logic [7:0]          rxsh;
    logic [3:0]          rbits;
    logic [7:0]          rx_data;
    logic                rx_valid;
    logic [7:0]          instr;
    logic [7:0]          txsh;
    logic [3:0]          tbits;
    logic [3:0]          dout;
    logic                sleep_arm;
    logic                wake_arm;
    logic                asleep;
  } fsi_q_t;

  fsi_q_t     q;
  fsi_q_t     next_q;
  logic       fifo_pop;
  logic       fifo_valid;
  logic [7:0] fifo_data;
  logic       rise;
  logic       fall;
  logic       cs_high;
  logic       cs_rise;
  logic       cs_fall;
  logic       rst_gate;
  logic       rst_fire;

  fsi_fifo #(
    .W (fsi_pkg::FIFO_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (tx_valid),
    .in_data   (tx_data),
    .in_ready  (tx_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_pop)
  );

  // Edges seen only after two-flop synchronisers
  assign rise     = q.sck_s[1] & ~q.sck_s[2];
  assign fall     = ~q.sck_s[1] & q.sck_s[2];
  assign cs_high  = q.cs_s[1];
  assign cs_rise  = q.cs_s[1] & ~q.cs_s[2];
  assign cs_fall  = ~q.cs_s[1] & q.cs_s[2];
  assign rst_gate = reset_enable && (!(quad_mode || all_quad_protocol) || cs_high);
  assign rst_fire = rst_gate && !q.io_b[fsi_pkg::IDX_DATA3] && q.rcnt >= RW'(RP_CYC - 1)
                    && q.st != fsi_pkg::ST_PWR_UP && q.st != fsi_pkg::ST_RST_BUSY;

  always_comb
  begin
    logic [3:0] w;
    logic [7:0] word;
    logic [7:0] ilim;
    next_q          = q;
    w               = 4'h4;
    word            = q.txsh;
    ilim            = all_quad_protocol ? fsi_pkg::INSTR_CYC_QPI : fsi_pkg::INSTR_CYC_SPI;
    fifo_pop        = 1'b0;
    next_q.sck_s    = {q.sck_s[1:0], sck};
    next_q.cs_s     = {q.cs_s[1:0], cs_n};
    next_q.io_a     = pin_in;
    next_q.io_b     = q.io_a;
    next_q.sup_s    = {q.sup_s[0], supply_good};
    next_q.rx_valid = 1'b0;
    next_q.rlvl     = q.io_b[fsi_pkg::IDX_DATA3];
    if (q.io_b[fsi_pkg::IDX_DATA3] != q.rlvl)
      next_q.rcnt = '0;
    else if (q.rcnt != '1)
      next_q.rcnt = q.rcnt + 1'b1;

    case (q.st)
      fsi_pkg::ST_INSTR: w = all_quad_protocol ? 4'h4 : 4'h1;
      fsi_pkg::ST_SIN, fsi_pkg::ST_SOUT: w = 4'h1;
      fsi_pkg::ST_DIN, fsi_pkg::ST_DOUT: w = 4'h2;
      default: w = 4'h4;
    endcase

    // Capture on rising edges, DDR input on both; latency cycles skipped
    if ((rise && (q.st == fsi_pkg::ST_INSTR || q.st == fsi_pkg::ST_SIN || q.st == fsi_pkg::ST_DIN
        || q.st == fsi_pkg::ST_QIN || q.st == fsi_pkg::ST_XIN)) || (fall && q.st == fsi_pkg::ST_XIN))
    begin
      if (w == 4'h1)
        next_q.rxsh = {q.rxsh[6:0], q.io_b[0]};
      else if (w == 4'h2)
        next_q.rxsh = {q.rxsh[5:0], q.io_b[1:0]};
      else
        next_q.rxsh = {q.rxsh[3:0], q.io_b};
      next_q.rbits = q.rbits + w;
      if (next_q.rbits == fsi_pkg::BYTE_BITS)
      begin
        next_q.rbits    = '0;
        next_q.rx_data  = next_q.rxsh;
        next_q.rx_valid = !q.asleep;
        if (q.st == fsi_pkg::ST_INSTR)
          next_q.instr = next_q.rxsh;
      end
    end

    // Shift out on falling edges, DDR output on both
    if ((fall && (q.st == fsi_pkg::ST_SOUT || q.st == fsi_pkg::ST_DOUT || q.st == fsi_pkg::ST_QOUT
        || q.st == fsi_pkg::ST_XOUT)) || (rise && q.st == fsi_pkg::ST_XOUT))
    begin
      if (q.tbits == '0)
      begin
        // Starved FIFO sends fill rather than stalling the host clock
        word     = fifo_valid ? fifo_data : fsi_pkg::IDLE_FILL;
        fifo_pop = fifo_valid;
      end
      next_q.txsh  = word << w;
      next_q.tbits = ((q.tbits == '0) ? fsi_pkg::BYTE_BITS : q.tbits) - w;
      if (w == 4'h1)
        next_q.dout = {2'b00, word[7], 1'b0};
      else if (w == 4'h2)
        next_q.dout = {2'b00, word[7:6]};
      else
        next_q.dout = word[7:4];
    end

    case (q.st)
      fsi_pkg::ST_PWR_UP:
      begin
        next_q.timer = q.timer - 1'b1;
        if (q.timer == '0)
          next_q.st = fsi_pkg::ST_STANDBY;
      end
      fsi_pkg::ST_STANDBY, fsi_pkg::ST_SLEEP:
      begin
        if (cs_fall)
        begin
          next_q.st    = fsi_pkg::ST_INSTR;
          next_q.pc    = '0;
          next_q.rbits = '0;
          next_q.wr    = 1'b0;
        end
      end
      fsi_pkg::ST_INSTR:
      begin
        if (rise)
          next_q.pc = q.pc + 1'b1;
        if (q.pc == ilim)
        begin
          next_q.pc    = '0;
          next_q.rbits = '0;
          next_q.tbits = '0;
          next_q.st    = fsi_pkg::ST_STANDBY;
          if (q.asleep)
            next_q.wake_arm = q.instr == fsi_pkg::CMD_RELEASE;
          else if (q.instr == fsi_pkg::CMD_DEEP_SLEEP)
            next_q.sleep_arm = !write_in_progress;
          else
          begin
            case (cmd_fmt)
              fsi_pkg::FMT_WRITE:
              begin
                next_q.st = fsi_pkg::ST_SIN;
                next_q.wr = 1'b1;
              end
              fsi_pkg::FMT_SREAD: next_q.st = fsi_pkg::ST_SIN;
              fsi_pkg::FMT_DREAD: next_q.st = fsi_pkg::ST_DIN;
              fsi_pkg::FMT_QREAD: next_q.st = fsi_pkg::ST_QIN;
              fsi_pkg::FMT_XREAD: next_q.st = fsi_pkg::ST_XIN;
              default: next_q.st = fsi_pkg::ST_STANDBY;
            endcase
            if (cmd_fmt >= fsi_pkg::FMT_SREAD && cmd_fmt <= fsi_pkg::FMT_XREAD && addr_cycles == '0)
              next_q.st = after_addr(next_q.st);
          end
        end
      end
      fsi_pkg::ST_SIN, fsi_pkg::ST_DIN, fsi_pkg::ST_QIN, fsi_pkg::ST_XIN:
      begin
        if (rise)
        begin
          next_q.pc = q.pc + 1'b1;
          if (!q.wr && next_q.pc == addr_cycles)
          begin
            next_q.st = after_addr(q.st);
            next_q.pc = '0;
          end
        end
      end
      fsi_pkg::ST_SLAT, fsi_pkg::ST_DLAT, fsi_pkg::ST_QLAT, fsi_pkg::ST_XLAT:
      begin
        if (rise)
        begin
          next_q.pc = q.pc + 1'b1;
          if (next_q.pc == latency_cycles)
            next_q.st = out_of(q.st);
        end
      end
      fsi_pkg::ST_RST_BUSY:
      begin
        if (q.timer != '0)
          next_q.timer = q.timer - 1'b1;
        else if (q.io_b[fsi_pkg::IDX_DATA3] && q.rcnt >= RW'(RH_CYC))
          next_q.st = fsi_pkg::ST_STANDBY;
      end
      fsi_pkg::ST_WAKE:
      begin
        next_q.timer = q.timer - 1'b1;
        if (q.timer == '0)
        begin
          next_q.st     = fsi_pkg::ST_STANDBY;
          next_q.asleep = 1'b0;
        end
      end
      default: next_q.st = q.st;
    endcase

    // CS rise ends any command, whatever phase it reached
    if (cs_rise && q.st != fsi_pkg::ST_PWR_UP && q.st != fsi_pkg::ST_RST_BUSY
        && q.st != fsi_pkg::ST_WAKE && q.st != fsi_pkg::ST_SLEEP)
    begin
      // Arms decided in this same cycle still count
      next_q.st        = fsi_pkg::ST_STANDBY;
      if (next_q.wake_arm)
      begin
        next_q.st    = fsi_pkg::ST_WAKE;
        next_q.timer = TW'(RES_CYC - 1);
      end
      else if (next_q.sleep_arm || q.asleep)
      begin
        next_q.st     = fsi_pkg::ST_SLEEP;
        next_q.asleep = 1'b1;
      end
      next_q.sleep_arm = 1'b0;
      next_q.wake_arm  = 1'b0;
    end
    if (rst_fire)
    begin
      next_q.st        = fsi_pkg::ST_RST_BUSY;
      next_q.timer     = TW'(RPH_CYC - 1);
      next_q.asleep    = 1'b0;
      next_q.sleep_arm = 1'b0;
      next_q.wake_arm  = 1'b0;
    end
    if (!q.sup_s[1])
    begin
      next_q.st        = fsi_pkg::ST_PWR_UP;
      next_q.timer     = TW'(PU_CYC - 1);
      next_q.asleep    = 1'b0;
      next_q.sleep_arm = 1'b0;
      next_q.wake_arm  = 1'b0;
      next_q.rx_valid  = 1'b0;
    end
  end

  function automatic fsi_pkg::fsi_state_t out_of(input fsi_pkg::fsi_state_t s);
    case (s)
      fsi_pkg::ST_SIN, fsi_pkg::ST_SLAT: return fsi_pkg::ST_SOUT;
      fsi_pkg::ST_DIN, fsi_pkg::ST_DLAT: return fsi_pkg::ST_DOUT;
      fsi_pkg::ST_QIN, fsi_pkg::ST_QLAT: return fsi_pkg::ST_QOUT;
      default: return fsi_pkg::ST_XOUT;
    endcase
  endfunction

  function automatic fsi_pkg::fsi_state_t after_addr(input fsi_pkg::fsi_state_t s);
    if (latency_cycles == '0)
      return out_of(s);
    case (s)
      fsi_pkg::ST_SIN: return fsi_pkg::ST_SLAT;
      fsi_pkg::ST_DIN: return fsi_pkg::ST_DLAT;
      fsi_pkg::ST_QIN: return fsi_pkg::ST_QLAT;
      default: return fsi_pkg::ST_XLAT;
    endcase
  endfunction

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      q       <= '0;
      q.st    <= fsi_pkg::ST_PWR_UP;
      q.timer <= TW'(PU_CYC - 1);
      q.sck_s <= '0;
      q.cs_s  <= 3'h7;
    end
    else
      q <= next_q;
  end

  // ****************************************
  // Pin drive
  // ****************************************
  always_comb
  begin
    case (q.st)
      fsi_pkg::ST_SOUT: pin_oe = fsi_pkg::OE_SINGLE;
      fsi_pkg::ST_DOUT: pin_oe = fsi_pkg::OE_DUAL;
      fsi_pkg::ST_QOUT, fsi_pkg::ST_XOUT: pin_oe = fsi_pkg::OE_QUAD;
      default: pin_oe = fsi_pkg::OE_NONE;
    endcase
  end

  assign pin_out    = q.dout;
  assign instr      = q.instr;
  assign rx_data    = q.rx_data;
  assign rx_valid   = q.rx_valid;
  assign state      = q.st;
  assign deep_sleep = q.asleep;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_low_supply_idle: assert property (!q.sup_s[1] |=> q.st == fsi_pkg::ST_PWR_UP && !rx_valid)
    else $error("Command state reached under low supply");
  a_powerup_silent: assert property (q.st == fsi_pkg::ST_PWR_UP |-> pin_oe == '0 ##1 !rx_valid)
    else $error("Activity during power-up");
  a_warm_reset_gate: assert property ($rose(q.st == fsi_pkg::ST_RST_BUSY)
    |-> $past(rst_gate) && !$past(q.io_b[3]) && $past(q.rcnt) >= RW'(RP_CYC - 1))
    else $error("Reset entered without a gated pulse");
  a_reset_exit: assert property (q.st == fsi_pkg::ST_RST_BUSY ##1 q.st == fsi_pkg::ST_STANDBY
    |-> $past(q.timer) == '0 && $past(q.rcnt) >= RW'(RH_CYC))
    else $error("Reset left early");
  a_cs_high_standby: assert property (cs_rise && (q.st == fsi_pkg::ST_QOUT || q.st == fsi_pkg::ST_INSTR)
    && !rst_fire && q.sup_s[1] |=> q.st inside {fsi_pkg::ST_STANDBY, fsi_pkg::ST_SLEEP, fsi_pkg::ST_WAKE})
    else $error("No standby after chip select rise");
  a_cs_fall_instr: assert property (cs_fall && q.st == fsi_pkg::ST_STANDBY && !rst_fire && q.sup_s[1]
    |=> q.st == fsi_pkg::ST_INSTR ##1 q.pc == '0)
    else $error("Instruction capture not started");
  a_sleep_idle: assert property ($rose(q.sleep_arm) |-> !$past(write_in_progress))
    else $error("Deep sleep accepted while busy");
  a_sleep_quiet: assert property (q.asleep |-> !rx_valid)
    else $error("Byte delivered while asleep");
  a_wake_delay: assert property (q.st == fsi_pkg::ST_WAKE ##1 q.st == fsi_pkg::ST_STANDBY
    |-> $past(q.timer) == '0)
    else $error("Wake delay cut short");
  a_data1_float: assert property (q.st inside {fsi_pkg::ST_PWR_UP, fsi_pkg::ST_RST_BUSY, fsi_pkg::ST_STANDBY,
    fsi_pkg::ST_INSTR, fsi_pkg::ST_SIN, fsi_pkg::ST_SLAT} |-> !pin_oe[1])
    else $error("Data1 driven in a quiet state");
  a_out_width: assert property (q.st inside {fsi_pkg::ST_SOUT, fsi_pkg::ST_DOUT, fsi_pkg::ST_QOUT,
    fsi_pkg::ST_XOUT} |-> pin_oe == (q.st == fsi_pkg::ST_SOUT ? fsi_pkg::OE_SINGLE
    : q.st == fsi_pkg::ST_DOUT ? fsi_pkg::OE_DUAL : fsi_pkg::OE_QUAD))
    else $error("Wrong drive width");
  a_latency_ignored: assert property (q.st inside {fsi_pkg::ST_DLAT, fsi_pkg::ST_QLAT, fsi_pkg::ST_XLAT}
    |=> $stable(q.rxsh) && pin_oe == '0 || q.st != $past(q.st))
    else $error("Latency cycle used or drove data");

  c_quad_read: cover property (q.st == fsi_pkg::ST_QLAT ##1 q.st == fsi_pkg::ST_QOUT);
  c_ddr_read: cover property (q.st == fsi_pkg::ST_XOUT && fifo_pop);
  c_sleep_wake: cover property (q.st == fsi_pkg::ST_WAKE ##1 q.st == fsi_pkg::ST_STANDBY);
  c_warm_reset: cover property (q.st == fsi_pkg::ST_RST_BUSY ##1 q.st == fsi_pkg::ST_STANDBY);
endmodule

// File: tb/fsi_host_model.sv
// Host-side flash controller model that drives the serial link pins
`timescale 1ns/10ps
module fsi_host_model (
  input  wire logic       mclk,    // System clock
  input  wire logic [3:0] pin_out, // Device pin levels
  input  wire logic [3:0] pin_oe,  // Device drive enables
  output logic            sck,     // Serial clock, idle low
  output logic            cs_n,    // Chip select
  output logic      [3:0] pin_in   // Resolved pin levels
);
  logic [3:0] h_out;
  logic [3:0] h_oe;
  logic       tog;
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    h_out = 4'hF;
    h_oe = 4'hC;
    tog = 1'b0;
  end
  // Released lines toggle so a stale level never passes as data
  always @(posedge mclk) tog <= ~tog;
  always_comb
    for (int i = 0; i < 4; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : (h_oe[i] ? h_out[i] : tog);
  // ****************************************
  // Link cycles: data set while low, sampled late in high phase
  // ****************************************
  task automatic cyc(input logic [3:0] oe, input int w, input int n, input logic [31:0] d, output logic [31:0] q);
    q = '0;
    for (int i = 0; i < n; i++)
    begin
      h_oe <= oe;
      h_out <= (w == 4) ? d[31:28] : {2'b11, (w == 2) ? d[31:30] : {1'b1, d[31]}};
      repeat (4) @(posedge mclk);
      sck <= 1'b1;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      q = (q << w) | 32'((w == 4) ? pin_in : (w == 2) ? {2'b00, pin_in[1:0]} : {3'b000, pin_in[1]});
      @(posedge mclk);
      sck <= 1'b0;
      d = d << w;
    end
  endtask
  task automatic desel();
    repeat (4) @(posedge mclk);
    cs_n <= 1'b1;
    h_oe <= 4'hC;
    h_out <= 4'hF;
    repeat (8) @(posedge mclk);
  endtask
  task automatic rst_pulse(input int n);
    h_out[3] <= 1'b0;
    repeat (n) @(posedge mclk);
    h_out[3] <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
endmodule

// File: tb/fsi_iface_states_test.sv
// Self-checking testbench for the flash interface state controller
`timescale 1ns/10ps
module fsi_iface_states_test;
  logic                mclk, reset, supply_good, reset_enable, quad_mode, write_in_progress, all_quad;
  logic                tx_valid, tx_ready, rx_valid, deep_sleep, sck, cs_n;
  logic [3:0]          pin_in, pin_out, pin_oe;
  logic [2:0]          cmd_fmt;
  logic [7:0]          addr_cycles, latency_cycles, instr, tx_data, rx_data;
  logic [31:0]         q;
  logic [7:0]          fifo_q[$];
  fsi_pkg::fsi_state_t state;
  int                  n_errors = 0;
  int                  num_checks = 0;
  int                  n_rx = 0;

  // Shortened power-up, reset busy and wake times keep the run brief
  fsi_iface_states #(.POWER_UP_NS(400), .RESET_BUSY_NS(400), .WAKE_NS(200)) fsi_iface_states_i (
    .mclk(mclk), .reset(reset), .supply_good(supply_good), .sck(sck), .cs_n(cs_n), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .reset_enable(reset_enable), .quad_mode(quad_mode),
    .all_quad_protocol(all_quad), .write_in_progress(write_in_progress), .cmd_fmt(cmd_fmt),
    .addr_cycles(addr_cycles), .latency_cycles(latency_cycles), .instr(instr), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .state(state),
    .deep_sleep(deep_sleep));
  fsi_host_model fsi_host_model_i (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .sck(sck), .cs_n(cs_n),
    .pin_in(pin_in));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) if (rx_valid === 1'b1) n_rx <= n_rx + 1;

  // ****************************************
  // Shared checking and bus tasks
  // ****************************************
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic wait_st(input fsi_pkg::fsi_state_t s, input int lim, output int n);
    for (n = 0; n < lim && state !== s; n++)
      @(posedge mclk);
    if (state !== s)
    begin
      chk(1'b0, "state wait ran out");
      wrap_up();
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    cmd_fmt <= fsi_pkg::FMT_NONE;
    fsi_host_model_i.cs_n <= 1'b0;
    fsi_host_model_i.cyc(4'hD, 1, 8, {c, 24'h0}, q);
    fsi_host_model_i.desel();
  endtask
  task automatic t_qpi();
    all_quad <= 1'b1;
    fsi_host_model_i.cs_n <= 1'b0;
    fsi_host_model_i.cyc(4'hF, 4, 2, {8'hC7, 24'h0}, q);
    fsi_host_model_i.desel();
    chk(instr === 8'hC7 && state === fsi_pkg::ST_STANDBY, "all-quad instruction");
    all_quad <= 1'b0;
  endtask
  task automatic t_write(input logic [7:0] b);
    cmd_fmt <= fsi_pkg::FMT_WRITE;
    fsi_host_model_i.cs_n <= 1'b0;
    fsi_host_model_i.cyc(4'hD, 1, 16, {8'h02, b, 16'h0}, q);
    chk(state === fsi_pkg::ST_SIN && pin_oe === 4'h0, "write stays input");
    fsi_host_model_i.desel();
    chk(rx_data === b && instr === 8'h02, "write byte");
  endtask
  // Words beyond the 16 that fit are refused and never expected back
  task automatic push(input int n, input logic [7:0] b0);
    for (int i = 0; i < n; i++)
    begin
      if (fifo_q.size() < 16) fifo_q.push_back(b0 + 8'(i));
      tx_data <= b0 + 8'(i);
      tx_valid <= 1'b1;
      @(posedge mclk);
    end
    tx_valid <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic t_read(input logic [2:0] f, input int w, input int lat, input logic [3:0] oe, input int nb);
    int n;
    cmd_fmt <= f;
    addr_cycles <= 8'(24 / w);
    latency_cycles <= 8'(lat);
    fsi_host_model_i.cs_n <= 1'b0;
    fsi_host_model_i.cyc(4'hD, 1, 8, {5'b00110, f, 24'h0}, q);
    chk(instr === {5'b00110, f} && pin_oe === 4'h0, "instruction capture");
    fsi_host_model_i.cyc(w == 1 ? 4'hD : 4'hF, w, 24 / w, 32'h0, q);
    if (lat > 0)
    begin
      fsi_host_model_i.cyc(w == 4 ? 4'h0 : 4'hC, 1, lat - 1, 32'h0, q);
      chk(pin_oe === 4'h0, "latency lines float");
      fsi_host_model_i.cyc(w == 4 ? 4'h0 : 4'hC, 1, 1, 32'h0, q);
    end
    for (int b = 0; b < nb; b++)
    begin
      fsi_host_model_i.cyc(w == 4 ? 4'h0 : 4'hC, w, 8 / w, 32'h0, q);
      chk(q[7:0] === (fifo_q.size() > 0 ? fifo_q.pop_front() : 8'hFF), "read byte");
      chk(pin_oe === oe, "output enables");
    end
    fsi_host_model_i.desel();
    wait_st(fsi_pkg::ST_STANDBY, 8, n);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    int n;
    reset = 1'b1;
    supply_good = 1'b1;
    reset_enable = 1'b0;
    quad_mode = 1'b0;
    all_quad = 1'b0;
    write_in_progress = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    cmd_fmt = 3'h0;
    addr_cycles = 8'h00;
    latency_cycles = 8'h00;
    repeat (20) @(posedge mclk);
    chk(state === fsi_pkg::ST_PWR_UP && pin_oe === 4'h0 && tx_ready === 1'b1, "reset values");
    reset <= 1'b0;
    wait_st(fsi_pkg::ST_STANDBY, 100, n);
    chk(n >= 45 && n <= 60, "power-up interval");
    cmd(8'h06);
    chk(instr === 8'h06 && state === fsi_pkg::ST_STANDBY, "standalone command");
    t_qpi();
    t_write(8'h5A);
    push(1, 8'hA5);
    t_read(fsi_pkg::FMT_SREAD, 1, 0, fsi_pkg::OE_SINGLE, 1);
    push(2, 8'h3C);
    t_read(fsi_pkg::FMT_DREAD, 2, 2, fsi_pkg::OE_DUAL, 2);
    push(17, 8'h10);
    chk(tx_ready === 1'b0, "fifo full");
    quad_mode <= 1'b1;
    t_read(fsi_pkg::FMT_QREAD, 4, 2, fsi_pkg::OE_QUAD, 17);
    write_in_progress <= 1'b1;
    cmd(fsi_pkg::CMD_DEEP_SLEEP);
    chk(deep_sleep === 1'b0, "sleep while busy");
    write_in_progress <= 1'b0;
    cmd(fsi_pkg::CMD_DEEP_SLEEP);
    n = n_rx;
    cmd(8'h06);
    chk(deep_sleep === 1'b1 && n_rx === n, "asleep ignores commands");
    cmd(fsi_pkg::CMD_RELEASE);
    wait_st(fsi_pkg::ST_STANDBY, 60, n);
    chk(deep_sleep === 1'b0, "release from sleep");
    supply_good <= 1'b0;
    n = n_rx;
    cmd(8'h06);
    chk(state === fsi_pkg::ST_PWR_UP && n_rx === n, "low supply");
    supply_good <= 1'b1;
    wait_st(fsi_pkg::ST_STANDBY, 100, n);
    reset_enable <= 1'b1;
    fsi_host_model_i.cs_n <= 1'b0;
    fsi_host_model_i.rst_pulse(40);
    chk(state === fsi_pkg::ST_INSTR, "no reset in quad while selected");
    fsi_host_model_i.desel();
    fsi_host_model_i.rst_pulse(40);
    chk(state === fsi_pkg::ST_RST_BUSY, "warm reset");
    wait_st(fsi_pkg::ST_STANDBY, 100, n);
    chk(n >= 20 && n <= 50, "reset busy time");
    wrap_up();
  end
endmodule
